//--- hdl/sspm_pkg.sv
package sspm_pkg;

	// ----------------------------------------
	// Register offsets
	// ----------------------------------------
	localparam logic [5:0] ADDR_INACT_THRESH = 6'h25;
	localparam logic [5:0] ADDR_INACT_TIME   = 6'h26;
	localparam logic [5:0] ADDR_RATE         = 6'h2c;
	localparam logic [5:0] ADDR_POWER        = 6'h2d;
	localparam logic [5:0] ADDR_FORMAT       = 6'h31;
	localparam logic [5:0] ADDR_SAMPLE       = 6'h32;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int BIT_LOW_POWER  = 4;
	localparam int BIT_MEASURE    = 3;
	localparam int BIT_AUTO_SLEEP = 4;
	localparam int BIT_LINK       = 5;
	localparam int BIT_THREE_WIRE = 6;
	localparam int RATE_CODE_MSB  = 3;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [7:0] RST_INACT_THRESH = 8'h00;
	localparam logic [7:0] RST_INACT_TIME   = 8'h00;
	localparam logic [7:0] RST_RATE         = 8'h0a;
	localparam logic [7:0] RST_POWER        = 8'h00;
	localparam logic [7:0] RST_FORMAT       = 8'h00;

	// ----------------------------------------
	// Rates and timing
	// ----------------------------------------
	localparam logic [3:0] RATE_CODE_TOP   = 4'hf;
	localparam logic [3:0] SLEEP_RATE_CODE = 4'h6;
	localparam int CORE_CLK_HZ      = 100_000_000;
	localparam int ODR_TOP_HZ       = 3200;
	localparam int RATE_BASE_CYCLES = CORE_CLK_HZ / ODR_TOP_HZ;
	localparam int SCLK_MAX_HZ      = 5_000_000;
	localparam int SCLK_MIN_CYCLES  = CORE_CLK_HZ / SCLK_MAX_HZ;
	localparam int FIFO_DEPTH       = 4;
	localparam int SAMPLE_WIDTH     = 8;

	// ----------------------------------------
	// Serial port phases
	// ----------------------------------------
	typedef enum logic [1:0] {
		SSPM_IDLE = 2'b00,
		SSPM_CMD  = 2'b01,
		SSPM_DATA = 2'b10
	} sspm_phase_t;

endpackage

//--- hdl/sspm_fifo.sv
`timescale 1ns/10ps
`default_nettype none
module sspm_fifo
	import sspm_pkg::*;
#(
	parameter int WIDTH = SAMPLE_WIDTH,
	parameter int DEPTH = FIFO_DEPTH
)
(
	input  wire logic             core_clk,
	input  wire logic             rst_b,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	generate
		if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
		begin : g_bad_depth
			$error("FIFO depth must be a power of two, at least 2");
		end
	endgenerate

	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW-1:0]    wr_ptr_reg;
	logic [AW-1:0]    rd_ptr_reg;
	logic [AW:0]      count_reg;
	logic             push;
	logic             pop;

	assign in_ready  = (count_reg != (AW+1)'(DEPTH));
	assign out_valid = (count_reg != '0);
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;
	assign out_data  = mem_reg[rd_ptr_reg];

	always_ff @(posedge core_clk)
	begin
		if (push)
			mem_reg[wr_ptr_reg] <= in_data;
	end

	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg  <= '0;
		end
		else
		begin
			if (push)
				wr_ptr_reg <= wr_ptr_reg + AW'(1);
			if (pop)
				rd_ptr_reg <= rd_ptr_reg + AW'(1);
			if (push && !pop)
				count_reg <= count_reg + (AW+1)'(1);
			else if (pop && !push)
				count_reg <= count_reg - (AW+1)'(1);
		end
	end
endmodule // sspm_fifo
`default_nettype wire

//--- hdl/sspm_top.sv
// Operation
// - Low-power bit halves internal sampling while output rate stays unchanged (not halved at rate code 0000).
// - Four-bit rate code; 1111 is 3200 Hz, each step down halves it.
// - Auto sleep plus link bits make device sleep at slow rate when quiet.
// - Clearing measure bit enters standby; no measurements are made.
// - Standby keeps sample FIFO contents intact.
// - Slave only; chip select held high means I2C, driven means SPI.
// - Format bit 6 selects 4-wire when 0, 3-wire shared line when 1.
// - SPI mode uses clock polarity 1, phase 1, clock up to 5 MHz.
// - Data changes on falling clock edge, captured on rising edge.
// - First byte carries read/write then multi-byte bit.
// - Multi-byte transfers advance the register pointer every eight clocks.
// - Setting measure bit moves device from standby into measurement.
// - All registers readable while in standby; all but the sample register writable.
`timescale 1ns/10ps
`default_nettype none
module sspm_top
	import sspm_pkg::*;
#(
	parameter int RATE_BASE = RATE_BASE_CYCLES,
	parameter int DEPTH     = FIFO_DEPTH
)
(
	input  wire logic                    core_clk,
	input  wire logic                    rst_b,
	input  wire logic                    cs_b_pin,
	input  wire logic                    sclk_pin,
	input  wire logic                    sdi_pin,
	output logic                         sdo_out,
	output logic                         sdo_oe,
	output logic                         sdio_out,
	output logic                         sdio_oe,
	input  wire logic [SAMPLE_WIDTH-1:0] sample_data,
	input  wire logic                    sample_valid,
	output logic                         sample_ready,
	output logic                         sample_tick,
	output logic                         output_tick,
	output logic                         measuring,
	output logic                         sleeping,
	output logic                         low_power_mode,
	output logic                         i2c_select,
	output logic      [3:0]              odr_code
);
	generate
		if (RATE_BASE < 1 || RATE_BASE > 65535)
		begin : g_bad_base
			$error("RATE_BASE must lie in 1..65535");
		end
	endgenerate

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [31:0] rate_period(input logic [3:0] code);
		logic [31:0] base;
		base = 32'(RATE_BASE);
		return base << (RATE_CODE_TOP - code);
	endfunction

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	logic [1:0] cs_sync_reg;
	logic [1:0] sclk_sync_reg;
	logic [1:0] sdi_sync_reg;
	logic       sclk_prev_reg;
	logic       cs_prev_reg;
	logic       cs_b;
	logic       sclk_s;
	logic       sclk_rise;
	logic       sclk_fall;

	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			cs_sync_reg   <= 2'h3;
			sclk_sync_reg <= 2'h3;
			sdi_sync_reg  <= 2'h0;
			sclk_prev_reg <= 1'b1;
			cs_prev_reg   <= 1'b1;
		end
		else
		begin
			cs_sync_reg   <= {cs_sync_reg[0], cs_b_pin};
			sclk_sync_reg <= {sclk_sync_reg[0], sclk_pin};
			sdi_sync_reg  <= {sdi_sync_reg[0], sdi_pin};
			sclk_prev_reg <= sclk_sync_reg[1];
			cs_prev_reg   <= cs_sync_reg[1];
		end
	end

	assign cs_b      = cs_sync_reg[1];
	assign sclk_s    = sclk_sync_reg[1];
	assign sclk_rise = !cs_b && sclk_s && !sclk_prev_reg;
	assign sclk_fall = !cs_b && !sclk_s && sclk_prev_reg;

	// ----------------------------------------
	// Interface mode select
	// ----------------------------------------
	logic spi_seen_reg;

	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
			spi_seen_reg <= 1'b0;
		else if (cs_prev_reg && !cs_b)
			spi_seen_reg <= 1'b1;
	end

	assign i2c_select = !spi_seen_reg;

	// ----------------------------------------
	// Serial engine
	// ----------------------------------------
	sspm_phase_t phase_reg;
	logic [2:0]  bit_cnt_reg;
	logic [7:0]  shift_in_reg;
	logic [7:0]  shift_in_next;
	logic [7:0]  tx_reg;
	logic        out_bit_reg;
	logic        drive_reg;
	logic        rd_reg;
	logic        multi_byte_flag_reg;
	logic        first_reg;
	logic [5:0]  addr_reg;
	logic        byte_done;
	logic        wr_stb;
	logic        load_stb;
	logic [7:0]  rd_data;

	assign shift_in_next = {shift_in_reg[6:0], sdi_sync_reg[1]};
	assign byte_done     = sclk_rise && (bit_cnt_reg == 3'h7);
	assign wr_stb        = byte_done && (phase_reg == SSPM_DATA) && !rd_reg
		&& (first_reg || multi_byte_flag_reg);
	assign load_stb      = sclk_fall && (phase_reg == SSPM_DATA) && rd_reg
		&& (bit_cnt_reg == 3'h0);

	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			phase_reg    <= SSPM_IDLE;
			bit_cnt_reg  <= 3'h0;
			shift_in_reg <= 8'h00;
			rd_reg       <= 1'b0;
			multi_byte_flag_reg <= 1'b0;
			first_reg    <= 1'b0;
			addr_reg     <= 6'h00;
		end
		else if (cs_b)
		begin
			phase_reg   <= SSPM_IDLE;
			bit_cnt_reg <= 3'h0;
		end
		else
		begin
			case (phase_reg)
				SSPM_IDLE:
					phase_reg <= SSPM_CMD;
				SSPM_CMD:
				begin
					if (byte_done)
					begin
						rd_reg    <= shift_in_next[7];
						multi_byte_flag_reg <= shift_in_next[6];
						addr_reg  <= shift_in_next[5:0];
						first_reg <= 1'b1;
						phase_reg <= SSPM_DATA;
					end
				end
				SSPM_DATA:
				begin
					if (byte_done)
					begin
						first_reg <= 1'b0;
						if (multi_byte_flag_reg)
							addr_reg <= addr_reg + 6'h01;
					end
				end
				default:
					phase_reg <= SSPM_IDLE;
			endcase
			if (sclk_rise)
			begin
				shift_in_reg <= shift_in_next;
				bit_cnt_reg  <= bit_cnt_reg + 3'h1;
			end
		end
	end

	// Output bit moves only on falling clock edges
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			tx_reg      <= 8'h00;
			out_bit_reg <= 1'b0;
			drive_reg   <= 1'b0;
		end
		else if (cs_b)
			drive_reg <= 1'b0;
		else if (load_stb)
		begin
			tx_reg      <= {rd_data[6:0], 1'b0};
			out_bit_reg <= rd_data[7];
			drive_reg   <= 1'b1;
		end
		else if (sclk_fall && drive_reg)
		begin
			tx_reg      <= {tx_reg[6:0], 1'b0};
			out_bit_reg <= tx_reg[7];
		end
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	logic [7:0] thresh_reg;
	logic [7:0] time_reg;
	logic [7:0] rate_reg;
	logic [7:0] power_reg;
	logic [7:0] format_reg;
	logic       three_wire;

	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			thresh_reg <= RST_INACT_THRESH;
			time_reg   <= RST_INACT_TIME;
			rate_reg   <= RST_RATE;
			power_reg  <= RST_POWER;
			format_reg <= RST_FORMAT;
		end
		else if (wr_stb)
		begin
			case (addr_reg)
				ADDR_INACT_THRESH: thresh_reg <= shift_in_next;
				ADDR_INACT_TIME:   time_reg   <= shift_in_next;
				ADDR_RATE:         rate_reg   <= shift_in_next;
				ADDR_POWER:        power_reg  <= shift_in_next;
				ADDR_FORMAT:       format_reg <= shift_in_next;
				default:           ;
			endcase
		end
	end

	// ----------------------------------------
	// Sample buffer
	// ----------------------------------------
	logic                    fifo_in_ready;
	logic                    fifo_out_valid;
	logic                    fifo_pop;
	logic [SAMPLE_WIDTH-1:0] fifo_out_data;

	assign fifo_pop = load_stb && (addr_reg == ADDR_SAMPLE)
		&& (first_reg || multi_byte_flag_reg);

	// Standby only gates the input; stored samples are never flushed
	sspm_fifo #(
		.WIDTH (SAMPLE_WIDTH),
		.DEPTH (DEPTH)
	) u_fifo (
		.core_clk  (core_clk),
		.rst_b     (rst_b),
		.in_valid  (sample_valid && measuring),
		.in_ready  (fifo_in_ready),
		.in_data   (sample_data),
		.out_valid (fifo_out_valid),
		.out_ready (fifo_pop),
		.out_data  (fifo_out_data)
	);

	assign sample_ready = fifo_in_ready && measuring;

	always_comb
	begin
		case (addr_reg)
			ADDR_INACT_THRESH: rd_data = thresh_reg;
			ADDR_INACT_TIME:   rd_data = time_reg;
			ADDR_RATE:         rd_data = rate_reg;
			ADDR_POWER:        rd_data = power_reg;
			ADDR_FORMAT:       rd_data = format_reg;
			ADDR_SAMPLE:       rd_data = fifo_out_valid ? fifo_out_data : 8'h00;
			default:           rd_data = 8'h00;
		endcase
	end

	// ----------------------------------------
	// Pin drivers
	// ----------------------------------------
	assign three_wire = format_reg[BIT_THREE_WIRE];
	assign sdo_out    = out_bit_reg;
	assign sdo_oe     = !cs_b && !three_wire;
	assign sdio_out   = out_bit_reg;
	assign sdio_oe    = !cs_b && three_wire && drive_reg;

	// ----------------------------------------
	// Power modes
	// ----------------------------------------
	logic       sleep_reg;
	logic [7:0] quiet_cnt_reg;
	logic [7:0] last_sample_reg;
	logic       auto_sleep_on;
	logic [3:0] out_code;
	logic [3:0] int_code;

	assign measuring      = power_reg[BIT_MEASURE];
	assign low_power_mode = rate_reg[BIT_LOW_POWER];
	assign auto_sleep_on  = power_reg[BIT_AUTO_SLEEP] && power_reg[BIT_LINK];
	assign sleeping       = sleep_reg;
	assign odr_code       = out_code;
	assign out_code       = sleep_reg ? SLEEP_RATE_CODE
		: rate_reg[RATE_CODE_MSB:0];

	// Internal sampling runs one step slower in low power mode, except at rate code 0000
	always_comb
	begin
		if (low_power_mode && out_code != 4'h0)
			int_code = out_code - 4'h1;
		else
			int_code = out_code;
	end

	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
			last_sample_reg <= 8'h00;
		else if (sample_valid && sample_ready)
			last_sample_reg <= sample_data;
	end

	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			sleep_reg     <= 1'b0;
			quiet_cnt_reg <= 8'h00;
		end
		else if (!auto_sleep_on || !measuring)
		begin
			sleep_reg     <= 1'b0;
			quiet_cnt_reg <= 8'h00;
		end
		else if (output_tick)
		begin
			if (last_sample_reg > thresh_reg)
			begin
				sleep_reg     <= 1'b0;
				quiet_cnt_reg <= 8'h00;
			end
			else if (quiet_cnt_reg >= time_reg && time_reg != 8'h00)
				sleep_reg <= 1'b1;
			else
				quiet_cnt_reg <= quiet_cnt_reg + 8'h01;
		end
	end

	// ----------------------------------------
	// Rate timers: output rate and internal rate
	// ----------------------------------------
	logic [1:0] tick;

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++)
		begin : g_timer
			logic [31:0] cnt_reg;
			logic [3:0]  code;
			assign code = (gi == 0) ? out_code : int_code;
			assign tick[gi] = measuring && (cnt_reg == 32'h0);
			always_ff @(posedge core_clk or negedge rst_b)
			begin
				if (!rst_b)
					cnt_reg <= 32'h0;
				else if (!measuring)
					cnt_reg <= 32'h0;
				else if (cnt_reg == 32'h0 || cnt_reg >= rate_period(code))
					cnt_reg <= rate_period(code) - 32'h1;
				else
					cnt_reg <= cnt_reg - 32'h1;
			end
		end
	endgenerate

	assign output_tick = tick[0];
	assign sample_tick = tick[1];

endmodule // sspm_top
`default_nettype wire

//--- sim/sspm_chk.sv
`timescale 1ns/10ps
`default_nettype none
module sspm_chk
	import sspm_pkg::*;
#(
	parameter int RATE_BASE = RATE_BASE_CYCLES,
	parameter int DEPTH     = FIFO_DEPTH
)
(
	input wire logic       core_clk,
	input wire logic       rst_b,
	input wire logic       cs_b_pin,
	input wire logic       sclk_pin,
	input wire logic       sdo_out,
	input wire logic       sdo_oe,
	input wire logic       sdio_oe,
	input wire logic       sample_ready,
	input wire logic       sample_tick,
	input wire logic       output_tick,
	input wire logic       measuring,
	input wire logic       sleeping,
	input wire logic       i2c_select,
	input wire logic [3:0] odr_code
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	// ----------------------------------------
	// Serial pins
	// ----------------------------------------
	a_cs_release: assert property ($rose(cs_b_pin) |-> ##[1:6] (!sdo_oe && !sdio_oe))
		else $error("data line still driven after deselect");
	a_one_driver: assert property (!(sdo_oe && sdio_oe))
		else $error("both data outputs enabled");
	a_out_hold: assert property ((sclk_pin && !cs_b_pin) [*8] |-> $stable(sdo_out))
		else $error("output bit moved while serial clock high");
	a_i2c_fall: assert property ($fell(i2c_select) |-> !cs_b_pin && $past(!cs_b_pin, 2))
		else $error("bus mode left without chip select");
	a_i2c_once: assert property (!i2c_select |=> !i2c_select)
		else $error("bus mode returned without reset");
	// ----------------------------------------
	// Power modes
	// ----------------------------------------
	a_ready_gate: assert property (sample_ready |-> measuring)
		else $error("samples accepted in standby");
	a_otick_gate: assert property (output_tick |-> measuring || $past(measuring))
		else $error("output tick in standby");
	a_stick_gate: assert property (sample_tick |-> measuring || $past(measuring))
		else $error("sample tick in standby");
	a_sleep_code: assert property (sleeping |-> odr_code == SLEEP_RATE_CODE)
		else $error("sleep without slow rate");
	c_sleep: cover property ($rose(sleeping));
	c_three: cover property (sdio_oe);
	c_full: cover property (measuring && !sample_ready);
endmodule // sspm_chk
`default_nettype wire

//--- sim/sspm_master.sv
`timescale 1ns/10ps
`default_nettype none
module sspm_master
(
	output logic       cs_b,
	output logic       sclk,
	output logic       sdi,
	input  wire logic  sdo_out,
	input  wire logic  sdo_oe,
	input  wire logic  sdio_out,
	input  wire logic  sdio_oe,
	output logic [7:0] rx_byte
);
	event       rx_ev;
	logic       m_oe = 1'b1;
	logic       m_bit = 1'b1;
	logic       sdio_last = 1'b0;
	logic       sdo_last = 1'b0;
	logic       sdo_w;
	// ----------------------------------------
	// Line levels
	// ----------------------------------------
	// A released line shows the inverse of its last driven level
	assign sdi = sdio_oe ? sdio_out : (m_oe ? m_bit : ~sdio_last);
	assign sdo_w = sdo_oe ? sdo_out : ~sdo_last;
	always @(sdi) if (sdio_oe || m_oe) sdio_last = sdi;
	always @(sdo_w) if (sdo_oe) sdo_last = sdo_w;
	initial
	begin
		cs_b = 1'b1;
		sclk = 1'b1;
	end
	// ----------------------------------------
	// One framed transfer
	// ----------------------------------------
	task automatic xfer(input logic tw, input logic rw, input logic multi_byte_flag,
		input logic [5:0] a, input int nb, input logic [15:0] wd);
		logic [23:0] sh;
		logic [7:0]  r;
		sh = {rw, multi_byte_flag, a, wd};
		r = 8'h00;
		#3 cs_b = 1'b0;
		#60;
		for (int i = 0; i < 8 + 8 * nb; i++)
		begin
			sclk = 1'b0;
			m_oe = !(tw && rw && i >= 8);
			m_bit = sh[23 - i];
			#80 sclk = 1'b1;
			r = {r[6:0], tw ? sdi : sdo_w};
			if (rw && i % 8 == 7 && i > 8)
			begin
				rx_byte = r;
				-> rx_ev;
			end
			#80;
		end
		cs_b = 1'b1;
		m_oe = !tw;
		// Whole clock periods per transfer, so pin changes never drift onto an edge
		#197;
	endtask
endmodule // sspm_master
`default_nettype wire

//--- sim/test_sspm_top.sv
`timescale 1ns/10ps
`default_nettype none
module test_sspm_top;
	import sspm_pkg::*;
	localparam int RB = 4;
	localparam int DP = 4;
	logic       core_clk, rst_b, cs_b_pin, sclk_pin, sdi_pin, sdo_out, sdo_oe;
	logic       sdio_out, sdio_oe, sample_valid, sample_ready, sample_tick, output_tick;
	logic       measuring, sleeping, low_power_mode, i2c_select, tw;
	logic [3:0] odr_code;
	logic [7:0] sample_data, d, e, exp_q[$], fq[$], rb[5], rv[5];
	logic [5:0] ra[5];
	int         num_errors, checked, seed, n;

	initial
	begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	sspm_master i_sspm_master (.cs_b(cs_b_pin), .sclk(sclk_pin), .sdi(sdi_pin), .sdo_out,
		.sdo_oe, .sdio_out, .sdio_oe, .rx_byte());
	sspm_top #(.RATE_BASE(RB), .DEPTH(DP)) i_sspm_top (.core_clk, .rst_b, .cs_b_pin,
		.sclk_pin, .sdi_pin, .sdo_out, .sdo_oe, .sdio_out, .sdio_oe, .sample_data,
		.sample_valid, .sample_ready, .sample_tick, .output_tick, .measuring, .sleeping,
		.low_power_mode, .i2c_select, .odr_code);

	// ----------------------------------------
	// Checking and bus tasks
	// ----------------------------------------
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic wr(input logic [5:0] a, input logic [7:0] v);
		i_sspm_master.xfer(tw, 1'b0, 1'b0, a, 1, {v, 8'h00});
	endtask
	task automatic rd(input logic [5:0] a, input logic [7:0] v);
		exp_q.push_back(v);
		i_sspm_master.xfer(tw, 1'b1, 1'b0, a, 1, 16'h0000);
	endtask
	task automatic tick_gap(input logic slow, output int gap);
		int k;
		for (k = 0; k < 3000; k++)
		begin
			@(posedge core_clk);
			if (slow ? sample_tick : output_tick)
				break;
		end
		for (gap = 1; gap < 3000; gap++)
		begin
			@(posedge core_clk);
			if (slow ? sample_tick : output_tick)
				break;
		end
		if (k == 3000 || gap == 3000)
		begin
			num_errors++;
			print_verdict();
		end
	endtask

	always @(i_sspm_master.rx_ev)
		check("read", i_sspm_master.rx_byte, exp_q.size() ? exp_q.pop_front() : 16'hxxxx);

	initial
	begin
		#900000;
		num_errors++;
		print_verdict();
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		seed = 1;
		rst_b = 1'b0;
		sample_valid = 1'b0;
		sample_data = 8'h00;
		tw = 1'b0;
		ra = '{ADDR_INACT_THRESH, ADDR_INACT_TIME, ADDR_RATE, ADDR_POWER, ADDR_FORMAT};
		rv = '{RST_INACT_THRESH, RST_INACT_TIME, RST_RATE, RST_POWER, RST_FORMAT};
		repeat (5) @(posedge core_clk);
		rst_b <= 1'b1;
		@(posedge core_clk);
		check("bus mode", i2c_select, 1'b1);
		check("rate after reset", odr_code, RST_RATE[3:0]);
		check("oe after reset", {sdo_oe, sdio_oe}, 2'b00);
		for (int i = 0; i < 5; i++)
			rd(ra[i], rv[i]);
		check("bus mode", i2c_select, 1'b0);
		for (int i = 0; i < 5; i++)
		begin
			rb[i] = $random(seed) & (ra[i] == ADDR_POWER ? 8'hc7 : 8'hbf);
			wr(ra[i], rb[i]);
		end
		for (int i = 0; i < 5; i++)
			rd(ra[i], rb[i]);
		$display("register access done");
		d = $random(seed);
		e = $random(seed);
		i_sspm_master.xfer(tw, 1'b0, 1'b1, ADDR_INACT_THRESH, 2, {d, e});
		exp_q.push_back(d);
		exp_q.push_back(e);
		i_sspm_master.xfer(tw, 1'b1, 1'b1, ADDR_INACT_THRESH, 2, 16'h0000);
		i_sspm_master.xfer(tw, 1'b0, 1'b0, ADDR_INACT_THRESH, 2, {~d, ~e});
		exp_q.push_back(~d);
		exp_q.push_back(~d);
		i_sspm_master.xfer(tw, 1'b1, 1'b0, ADDR_INACT_THRESH, 2, 16'h0000);
		rd(ADDR_INACT_TIME, e);
		wr(6'h00, 8'h5a);
		rd(6'h00, 8'h00);
		$display("multi-byte done");
		wr(ADDR_FORMAT, 8'h40);
		tw = 1'b1;
		rd(ADDR_FORMAT, 8'h40);
		rd(ADDR_INACT_TIME, e);
		wr(ADDR_FORMAT, 8'h00);
		tw = 1'b0;
		rd(ADDR_FORMAT, 8'h00);
		$display("wire modes done");
		wr(ADDR_POWER, 8'h08);
		check("measuring", measuring, 1'b1);
		for (int c = 15; c >= 0; c--)
		begin
			d = {3'b000, c >= 7 && c <= 12, c[3:0]};
			wr(ADDR_RATE, d);
			check("rate code", odr_code, d[3:0]);
			check("low power", low_power_mode, d[4]);
			if (c >= 11)
			begin
				tick_gap(1'b0, n);
				tick_gap(1'b0, n);
				check("output gap", n, RB << (15 - c));
				tick_gap(1'b1, n);
				tick_gap(1'b1, n);
				check("sample gap", n, RB << (15 - c + d[4]));
			end
		end
		$display("rates done");
		@(posedge core_clk);
		sample_valid <= 1'b1;
		sample_data <= $random(seed);
		for (n = 0; n < 20; n++)
		begin
			@(posedge core_clk);
			if (!sample_ready)
				break;
			fq.push_back(sample_data);
			sample_data <= $random(seed);
		end
		sample_valid <= 1'b0;
		check("fill count", fq.size(), DP);
		wr(ADDR_POWER, 8'h00);
		check("standby", {measuring, sample_ready}, 2'b00);
		for (n = 0; n < DP; n++)
			rd(ADDR_SAMPLE, fq[n]);
		rd(ADDR_SAMPLE, 8'h00);
		$display("standby done");
		wr(ADDR_RATE, 8'h0f);
		wr(ADDR_INACT_THRESH, 8'hff);
		wr(ADDR_INACT_TIME, 8'h02);
		wr(ADDR_POWER, 8'h38);
		for (n = 0; n < 500 && sleeping !== 1'b1; n++)
			@(posedge core_clk);
		check("sleeping", sleeping, 1'b1);
		check("sleep rate", odr_code, SLEEP_RATE_CODE);
		wr(ADDR_INACT_THRESH, 8'h00);
		for (n = 0; n < 3000 && sleeping === 1'b1; n++)
			@(posedge core_clk);
		check("wake", sleeping, fq[DP-1] == 8'h00);
		check("leftover", exp_q.size(), 0);
		$display("auto sleep done");
		print_verdict();
	end
endmodule // test_sspm_top

bind sspm_top sspm_chk #(.RATE_BASE(RATE_BASE), .DEPTH(DEPTH)) i_sspm_chk (.core_clk, .rst_b,
	.cs_b_pin, .sclk_pin, .sdo_out, .sdo_oe, .sdio_oe, .sample_ready, .sample_tick,
	.output_tick, .measuring, .sleeping, .i2c_select, .odr_code);
`default_nettype wire
